// File: pkg/brs_pkg.sv
// constants, layout and scheduling function of the rate frame sequencer
// How it works
// RULE1: every stack entry holds its rate code
// RULE2: rate 1/N first in frame N/2-1, then every N
// RULE3: each frame: full rate plus one slower class
// RULE4: per-entry skew 0..15 frames delays the slot
// RULE5: skew shifts phase, never the period
// RULE6: host repeats entries for non-power-of-two rates
// RULE7: stack at 0x50, eight words per entry
// RULE8: data block i at base plus 32*i
// RULE9: device alone writes findings and state blocks; host writes to the state blocks are not blocked
// RULE10: host writes configuration, stack and outgoing data
// RULE11: host touches spare fields only while stopped
// RULE12: start loads pointer and length, tracks progress
package brs_pkg;
	localparam int AW = 12;
	localparam int DW = 16;
	localparam int MEM_DEPTH = 4096;
	localparam logic [11:0] FIND_LO = 12'h020;
	localparam logic [11:0] FIND_HI = 12'h02F;
	localparam logic [11:0] FIND_FRAME = 12'h020;
	localparam logic [11:0] FIND_SENT = 12'h021;
	localparam logic [11:0] INIT_PTR_ADDR = 12'h030;
	localparam logic [11:0] INIT_LEN_ADDR = 12'h031;
	localparam logic [11:0] CUR_ENTRY_ADDR = 12'h032;
	localparam logic [11:0] REMAIN_ADDR = 12'h033;
	localparam logic [11:0] START_ADDR = 12'h034;
	localparam logic [11:0] CFG_LO = 12'h040;
	localparam logic [11:0] CFG_HI = 12'h04F;
	localparam logic [15:0] STACK_BASE = 16'h0050;
	localparam logic [15:0] ENTRY_WORDS = 16'h0008;
	localparam logic [11:0] DATA_BASE = 12'h250;
	localparam logic [11:0] STATE_BASE = 12'hA50;
	localparam int BLOCK_SHIFT = 5;
	localparam int STATE_SHIFT = 2;
	localparam int RATE_LSB = 0;
	localparam int SKEW_LSB = 4;
	localparam int START_RUN_BIT = 0;
	localparam logic [15:0] RESET_LEN = 16'h0000;
	localparam logic [15:0] RESET_FRAME = 16'h0000;

	typedef enum logic [3:0] {
		BRS_IDLE = 4'h0,
		BRS_WAITF = 4'h1,
		BRS_ENTRY = 4'h2,
		BRS_CHECK = 4'h3,
		BRS_SEND = 4'h4,
		BRS_LOG = 4'h5,
		BRS_NEXT = 4'h6,
		BRS_FRAME = 4'h7,
		BRS_FRAME2 = 4'h8
	} brs_state_t;

	// slot test: phase of the skewed frame within the 2^rate cycle must be N/2-1
	function automatic logic brs_due(input logic [15:0] frame, input logic [3:0] rate, input logic [3:0] skew);
		logic [15:0] mask;
		logic [15:0] ph;
		mask = (16'h0001 << rate) - 16'h0001;
		ph = (frame - {12'h000, skew}) & mask;
		brs_due = (ph == (mask >> 1));
	endfunction
endpackage

// File: verilog/brs_mem.sv
// shared 16-bit word memory with a host port and a sequencer port
`timescale 1ns/100ps
module brs_mem (
	input wire logic CLK,
	input wire logic a_we,
	input wire logic [11:0] a_addr,
	input wire logic [15:0] a_wdata,
	output logic [15:0] a_rdata,
	input wire logic b_we,
	input wire logic [11:0] b_addr,
	input wire logic [15:0] b_wdata,
	output logic [15:0] b_rdata
);
	typedef struct packed {
		logic [15:0] ra;
		logic [15:0] rb;
	} brs_mem_t;

	logic [15:0] mem [0:brs_pkg::MEM_DEPTH-1];
	brs_mem_t s;
	brs_mem_t next_s;

	// no reset on the array: its contents are the host's to load
	always_comb begin
		next_s.ra = mem[a_addr];
		next_s.rb = mem[b_addr];
	end

	// both ports write; the sequencer never targets host-owned words
	always_ff @(posedge CLK) begin
		s <= next_s;
		if (a_we) begin
			mem[a_addr] <= a_wdata;
		end
		if (b_we) begin
			mem[b_addr] <= b_wdata;
		end
	end

	assign a_rdata = s.ra;
	assign b_rdata = s.rb;
endmodule // brs_mem

// File: verilog/brs_seq.sv
// message sequencer: walks the stack each frame and launches the due messages
`timescale 1ns/100ps
module brs_seq (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic [11:0] HOST_ADDR,
	input wire logic HOST_WE,
	input wire logic [15:0] HOST_WDATA,
	output logic [15:0] HOST_RDATA,
	input wire logic FRAME_START,
	output logic MSG_GO,
	input wire logic MSG_DONE,
	output logic [15:0] MSG_ENTRY,
	output logic [7:0] MSG_INDEX,
	output logic [11:0] MSG_DATA_ADDR,
	output logic [15:0] FRAME_NUM,
	output logic RUNNING
);
	typedef struct packed {
		brs_pkg::brs_state_t st;
		logic run;
		logic [15:0] init_ptr;
		logic [15:0] init_len;
		logic [15:0] cur;
		logic [15:0] rem;
		logic [15:0] frame;
		logic [15:0] sent;
		logic [7:0] idx;
		logic [3:0] rate;
		logic [3:0] skew;
		logic [11:0] data_addr;
	} brs_seq_t;

	brs_seq_t s;
	brs_seq_t next_s;
	logic host_ok;
	logic start_wr;
	logic b_we;
	logic [11:0] b_addr;
	logic [15:0] b_wdata;
	logic [15:0] b_rdata;

	// host writes into the findings area and live words are dropped
	assign host_ok = HOST_WE && !((HOST_ADDR >= brs_pkg::FIND_LO) && (HOST_ADDR <= brs_pkg::FIND_HI))
		&& (HOST_ADDR != brs_pkg::CUR_ENTRY_ADDR) && (HOST_ADDR != brs_pkg::REMAIN_ADDR); // RULE9
	assign start_wr = HOST_WE && (HOST_ADDR == brs_pkg::START_ADDR);

	brs_mem u_mem (
		.CLK(CLK),
		.a_we(host_ok),
		.a_addr(HOST_ADDR),
		.a_wdata(HOST_WDATA),
		.a_rdata(HOST_RDATA),
		.b_we(b_we),
		.b_addr(b_addr),
		.b_wdata(b_wdata),
		.b_rdata(b_rdata)
	);

	// sequencer port: one read or one write per state
	always_comb begin
		b_we = 1'b0;
		b_addr = s.cur[11:0];
		b_wdata = 16'h0000;
		unique case (s.st)
			brs_pkg::BRS_CHECK: begin
				b_we = 1'b1;
				b_addr = brs_pkg::CUR_ENTRY_ADDR;
				b_wdata = s.cur; // RULE12
			end
			brs_pkg::BRS_LOG: begin
				b_we = 1'b1;
				b_addr = brs_pkg::STATE_BASE + {2'h0, s.idx[9-brs_pkg::STATE_SHIFT:0], 2'h0}; // RULE9
				b_wdata = s.frame;
			end
			brs_pkg::BRS_NEXT: begin
				b_we = 1'b1;
				b_addr = brs_pkg::REMAIN_ADDR;
				b_wdata = s.rem - 16'h0001; // RULE12
			end
			brs_pkg::BRS_FRAME: begin
				b_we = 1'b1;
				b_addr = brs_pkg::FIND_FRAME; // RULE9
				b_wdata = s.frame;
			end
			brs_pkg::BRS_FRAME2: begin
				b_we = 1'b1;
				b_addr = brs_pkg::FIND_SENT;
				b_wdata = s.sent;
			end
			brs_pkg::BRS_IDLE, brs_pkg::BRS_WAITF, brs_pkg::BRS_ENTRY, brs_pkg::BRS_SEND: begin
				b_we = 1'b0;
			end
		endcase
	end

	// next state; a stop only lands between frames so a launched message completes
	always_comb begin
		next_s = s;
		if (host_ok && HOST_ADDR == brs_pkg::INIT_PTR_ADDR) begin
			next_s.init_ptr = HOST_WDATA;
		end
		if (host_ok && HOST_ADDR == brs_pkg::INIT_LEN_ADDR) begin
			next_s.init_len = HOST_WDATA;
		end
		if (start_wr) begin
			next_s.run = HOST_WDATA[brs_pkg::START_RUN_BIT];
		end
		unique case (s.st)
			brs_pkg::BRS_IDLE: begin
				if (start_wr && HOST_WDATA[brs_pkg::START_RUN_BIT]) begin
					next_s.st = brs_pkg::BRS_WAITF;
					next_s.frame = brs_pkg::RESET_FRAME;
					next_s.cur = s.init_ptr; // RULE12
					next_s.rem = s.init_len;
				end
			end
			brs_pkg::BRS_WAITF: begin
				if (!s.run) begin
					next_s.st = brs_pkg::BRS_IDLE;
				end else if (FRAME_START) begin
					next_s.st = brs_pkg::BRS_ENTRY;
					next_s.cur = s.init_ptr; // RULE12
					next_s.rem = s.init_len;
					next_s.idx = 8'h00;
					next_s.sent = 16'h0000;
				end
			end
			brs_pkg::BRS_ENTRY: begin
				next_s.st = (s.rem == 16'h0000) ? brs_pkg::BRS_FRAME : brs_pkg::BRS_CHECK;
			end
			brs_pkg::BRS_CHECK: begin
				// rate and skew sit in the first word of the entry
				next_s.rate = b_rdata[brs_pkg::RATE_LSB +: 4]; // RULE1
				next_s.skew = b_rdata[brs_pkg::SKEW_LSB +: 4]; // RULE4
				next_s.data_addr = brs_pkg::DATA_BASE + {s.idx[6:0], 5'h00}; // RULE8
				next_s.st = brs_pkg::brs_due(s.frame, b_rdata[brs_pkg::RATE_LSB +: 4],
					b_rdata[brs_pkg::SKEW_LSB +: 4]) ? brs_pkg::BRS_SEND : brs_pkg::BRS_NEXT; // RULE2 RULE3 RULE5
			end
			brs_pkg::BRS_SEND: begin
				if (MSG_DONE) begin
					next_s.st = brs_pkg::BRS_LOG;
				end
			end
			brs_pkg::BRS_LOG: begin
				next_s.sent = s.sent + 16'h0001;
				next_s.st = brs_pkg::BRS_NEXT;
			end
			brs_pkg::BRS_NEXT: begin
				next_s.cur = s.cur + brs_pkg::ENTRY_WORDS; // RULE7
				next_s.rem = s.rem - 16'h0001;
				next_s.idx = s.idx + 8'h01;
				next_s.st = brs_pkg::BRS_ENTRY;
			end
			brs_pkg::BRS_FRAME: begin
				next_s.st = brs_pkg::BRS_FRAME2;
			end
			brs_pkg::BRS_FRAME2: begin
				next_s.frame = s.frame + 16'h0001;
				next_s.st = brs_pkg::BRS_WAITF;
			end
			default: begin
				next_s.st = brs_pkg::BRS_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge CLK) begin
		if (SRST) begin
			s <= '0;
			s.st <= brs_pkg::BRS_IDLE;
			s.init_ptr <= brs_pkg::STACK_BASE;
			s.init_len <= brs_pkg::RESET_LEN;
			s.cur <= brs_pkg::STACK_BASE;
		end else begin
			s <= next_s;
		end
	end

	assign MSG_GO = (s.st == brs_pkg::BRS_SEND);
	assign MSG_ENTRY = s.cur;
	assign MSG_INDEX = s.idx;
	assign MSG_DATA_ADDR = s.data_addr;
	assign FRAME_NUM = s.frame;
	assign RUNNING = s.run;

	// only messages in their slot are launched
	go_due_a: assert property (@(posedge CLK) disable iff (SRST) // RULE2
		s.st == brs_pkg::BRS_SEND |-> brs_pkg::brs_due(s.frame, s.rate, s.skew))
		else $error("message launched outside its frame slot");
	class_a: assert property (@(posedge CLK) disable iff (SRST) // RULE3
		$rose(MSG_GO) && s.skew == 4'h0 && s.rate != 4'h0 |-> s.frame[s.rate - 4'h1] == 1'b0
		&& (((s.frame + 16'h0001) & ((16'h0001 << (s.rate - 4'h1)) - 16'h0001)) == 16'h0000))
		else $error("slower class served in wrong frame");
	rate_load_a: assert property (@(posedge CLK) disable iff (SRST) // RULE1
		s.st == brs_pkg::BRS_CHECK |=> s.rate == $past(b_rdata[3:0]) && s.skew == $past(b_rdata[7:4]))
		else $error("rate or skew not taken from entry");
	skew_a: assert property (@(posedge CLK) disable iff (SRST) // RULE4
		$rose(MSG_GO) |-> brs_pkg::brs_due(s.frame - {12'h000, s.skew}, s.rate, 4'h0))
		else $error("skew does not delay the slot");
	period_a: assert property (@(posedge CLK) disable iff (SRST) // RULE5
		$rose(MSG_GO) |-> !brs_pkg::brs_due(s.frame + 16'h0001, s.rate, s.skew) || s.rate == 4'h0)
		else $error("skewed message repeats too soon");
	step_a: assert property (@(posedge CLK) disable iff (SRST) // RULE7
		s.st == brs_pkg::BRS_NEXT |=> s.cur == $past(s.cur) + 16'h0008 && s.st == brs_pkg::BRS_ENTRY)
		else $error("entry stride is not eight words");
	data_a: assert property (@(posedge CLK) disable iff (SRST) // RULE8
		MSG_GO |-> MSG_DATA_ADDR == brs_pkg::DATA_BASE + {s.idx[6:0], 5'h00})
		else $error("data block address wrong");
	find_a: assert property (@(posedge CLK) disable iff (SRST) // RULE9
		s.st == brs_pkg::BRS_FRAME |-> b_we && b_addr == brs_pkg::FIND_FRAME ##2 s.frame == $past(s.frame, 2) + 16'h0001)
		else $error("frame finding not written");
	start_a: assert property (@(posedge CLK) disable iff (SRST) // RULE12
		s.st == brs_pkg::BRS_IDLE && start_wr && HOST_WDATA[0] |=> s.st == brs_pkg::BRS_WAITF && s.cur == s.init_ptr
		&& s.frame == 16'h0000)
		else $error("start did not load the stack pointer");
	hold_a: assert property (@(posedge CLK) disable iff (SRST)
		MSG_GO && !MSG_DONE |=> MSG_GO && $stable(MSG_ENTRY))
		else $error("request dropped before done");

	send_c: cover property (@(posedge CLK) disable iff (SRST) $rose(MSG_GO) && s.rate == 4'h3);
	skewed_c: cover property (@(posedge CLK) disable iff (SRST) $rose(MSG_GO) && s.skew != 4'h0);
	frame_c: cover property (@(posedge CLK) disable iff (SRST) s.st == brs_pkg::BRS_FRAME2 && s.sent > 16'h0001);
endmodule // brs_seq

// File: dv/brs_engine.sv
// transmit engine model answering the sequencer's launch requests
`timescale 1ns/100ps
module brs_engine (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic MSG_GO,
	output logic MSG_DONE
);
	logic [2:0] cnt;
	logic slow;

	// answers alternate prompt and slow, so both launch timings get exercised
	always_ff @(posedge CLK) begin
		if (SRST) begin
			MSG_DONE <= 1'h0;
			cnt <= 3'h0;
			slow <= 1'h0;
		end else if (MSG_DONE) begin
			MSG_DONE <= 1'h0; // one-cycle done, then wait for the next launch
			cnt <= 3'h0;
			slow <= !slow;
		end else if (MSG_GO) begin
			if (cnt == (slow ? 3'h5 : 3'h0))
				MSG_DONE <= 1'h1;
			else
				cnt <= cnt + 3'h1;
		end
	end
endmodule // brs_engine

// File: dv/brs_seq_bench.sv
// bench for the rate frame sequencer: stack load, frame walk, findings
`timescale 1ns/100ps
module brs_seq_bench;
	logic CLK, SRST, HOST_WE, FRAME_START, MSG_GO, MSG_DONE, RUNNING;
	logic [11:0] HOST_ADDR, MSG_DATA_ADDR;
	logic [15:0] HOST_WDATA, HOST_RDATA, MSG_ENTRY, FRAME_NUM, rd_val;
	logic [7:0] MSG_INDEX;
	logic [3:0] got, exp_mask;
	int err_count = 0, total_checks = 0, launches = 0, stacked = 0, n_exp, t;
	// entries 1 to 3 stand for one message stacked at three rates to reach an odd rate
	int rate_tab[4] = '{0, 3, 1, 4};
	int skew_tab[4] = '{0, 0, 1, 15};

	brs_seq dut (.CLK(CLK), .SRST(SRST), .HOST_ADDR(HOST_ADDR), .HOST_WE(HOST_WE), .HOST_WDATA(HOST_WDATA),
		.HOST_RDATA(HOST_RDATA), .FRAME_START(FRAME_START), .MSG_GO(MSG_GO), .MSG_DONE(MSG_DONE),
		.MSG_ENTRY(MSG_ENTRY), .MSG_INDEX(MSG_INDEX), .MSG_DATA_ADDR(MSG_DATA_ADDR), .FRAME_NUM(FRAME_NUM),
		.RUNNING(RUNNING));
	brs_engine eng (.CLK(CLK), .SRST(SRST), .MSG_GO(MSG_GO), .MSG_DONE(MSG_DONE));

	initial begin
		CLK = 1'h0;
		forever #2 CLK = !CLK;
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge CLK);
		HOST_ADDR <= a;
		HOST_WE <= 1'h1;
		HOST_WDATA <= d;
		@(posedge CLK);
		HOST_WE <= 1'h0;
	endtask

	// read data is registered: valid one edge after the address is taken
	task automatic rd(input logic [11:0] a);
		@(posedge CLK);
		HOST_ADDR <= a;
		@(posedge CLK);
		#1 rd_val = HOST_RDATA;
	endtask

	// slot rule worked out independently of the design's helper
	function automatic bit due(input int f, input int k, input int s);
		int n;
		n = 1 << k;
		if (k == 0)
			return 1'b1;
		return ((f - s + 16 * n) % n) == (n / 2 - 1);
	endfunction

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// every launch must point at its own stack entry and data block
	always @(posedge CLK) begin
		if (MSG_GO === 1'h1 && MSG_DONE === 1'h1) begin
			got[MSG_INDEX[1:0]] = 1'b1;
			launches++;
			if (MSG_INDEX != 8'h00)
				stacked++;
			chk("entry addr", 16'h0050 + 16'h0008 * {8'h00, MSG_INDEX}, MSG_ENTRY);
			chk("data addr", {4'h0, brs_pkg::DATA_BASE} + 16'h0020 * {8'h00, MSG_INDEX}, {4'h0, MSG_DATA_ADDR});
		end
	end

	// watchdog: 17 frames of under 100 cycles each plus setup
	initial begin
		repeat (20000) @(posedge CLK);
		err_count++;
		tally_and_finish();
	end

	initial begin
		SRST = 1'h1;
		HOST_ADDR = 12'h000;
		HOST_WE = 1'h0;
		HOST_WDATA = 16'h0000;
		FRAME_START = 1'h0;
		got = 4'h0;
		repeat (4) @(posedge CLK);
		SRST <= 1'h0;
		#1 chk("reset go", 16'h0000, {15'h0000, MSG_GO});
		chk("reset run", 16'h0000, {15'h0000, RUNNING});
		chk("reset frame", 16'h0000, FRAME_NUM);
		chk("reset entry", 16'h0050, MSG_ENTRY);
		$display("test reset done");
		// stack loaded before the run command, spare words left alone
		for (int i = 0; i < 4; i++)
			wr(12'h050 + 12'h008 * i[11:0], {8'h00, skew_tab[i][3:0], rate_tab[i][3:0]});
		wr(brs_pkg::INIT_PTR_ADDR, 16'h0050);
		wr(brs_pkg::INIT_LEN_ADDR, 16'h0004);
		wr(brs_pkg::START_ADDR, 16'h0001);
		@(posedge CLK);
		#1 chk("running", 16'h0001, {15'h0000, RUNNING});
		for (int f = 0; f < 16; f++) begin
			got = 4'h0;
			n_exp = 0;
			@(posedge CLK);
			FRAME_START <= 1'h1;
			@(posedge CLK);
			FRAME_START <= 1'h0;
			// look just after each edge so the frame count has settled
			for (t = 0; t < 200 && FRAME_NUM !== f[15:0] + 16'h0001; t++) begin
				@(posedge CLK);
				#1;
			end
			chk("frame num", f[15:0] + 16'h0001, FRAME_NUM);
			for (int i = 0; i < 4; i++) begin
				exp_mask[i] = due(f, rate_tab[i], skew_tab[i]);
				n_exp += exp_mask[i];
			end
			chk("due set", {12'h000, exp_mask}, {12'h000, got});
			wr(brs_pkg::FIND_FRAME, 16'hFFFF);
			wr(brs_pkg::REMAIN_ADDR, 16'h00AA);
			rd(brs_pkg::FIND_FRAME);
			chk("finding frame", f[15:0], rd_val);
			rd(brs_pkg::FIND_SENT);
			chk("finding sent", n_exp[15:0], rd_val);
			rd(brs_pkg::REMAIN_ADDR);
			chk("remaining", 16'h0000, rd_val);
			rd(brs_pkg::CUR_ENTRY_ADDR);
			chk("current entry", 16'h0050 + 16'h0008 * 16'h0003, rd_val);
			rd(brs_pkg::STATE_BASE);
			chk("state frame", f[15:0], rd_val);
		end
		// sixteen frames hold a whole number of periods of every stacked rate
		n_exp = 0;
		for (int i = 1; i < 4; i++)
			n_exp += 16 >> rate_tab[i];
		chk("stacked repeats", n_exp[15:0], stacked[15:0]);
		$display("test frame walk done");
		// stop lands between frames: a later tick launches nothing
		wr(brs_pkg::START_ADDR, 16'h0000);
		n_exp = launches;
		@(posedge CLK);
		FRAME_START <= 1'h1;
		@(posedge CLK);
		FRAME_START <= 1'h0;
		repeat (40) @(posedge CLK);
		chk("stopped launches", n_exp[15:0], launches[15:0]);
		chk("stopped run", 16'h0000, {15'h0000, RUNNING});
		$display("test stop done");
		// a reset after the stop must clear the frame count and put the walk position back at the stack base
		@(posedge CLK);
		SRST <= 1'h1;
		repeat (2) @(posedge CLK);
		SRST <= 1'h0;
		#1 chk("rerun reset frame", 16'h0000, FRAME_NUM);
		chk("rerun reset entry", 16'h0050, MSG_ENTRY);
		chk("rerun reset run", 16'h0000, {15'h0000, RUNNING});
		$display("test second reset done");
		tally_and_finish();
	end
endmodule // brs_seq_bench
